//--- design/sbol_loader.v
`include "sbol_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - bit 5 selects otp boot, else flash
// - image opens with 32-bit word count
// - crc trailer; magic value skips check
// - size and crc little-endian bytes
// - program from ram base, started there
// - crc covers size word and program
// - reflected edb88320, preset ones, inverted
// - bit 0 blocks test port access
// - bit 1 refuses switch state access
// - bit 7 enables otp redundant rows
// - bits 8..11 lock sectors 0..3
// - bit 12 locks all otp programming
// - bit 13 denies test port otp access
// - bit 14 ignores global debug pin
// - bits 21:15 general purpose readable field
// - bits 31:22 test user code extension
// - security word loaded before boot choice
// - otp image copied to sram, run first
// - otp is four sectors of 512 rows
// - programming address port id 100200
// - programming data port id 200100
// - programming control port id 100300
module sbol_loader (
  // clock and reset
  input wire clk,
  input wire rst,
  // otp read port
  output reg otp_rd_req,
  output reg otp_rd_sec,
  output reg [`SBOL_OTP_AW-1:0] otp_rd_addr,
  input wire otp_rd_valid,
  input wire [31:0] otp_rd_data,
  // flash read port
  output reg flash_rd_req,
  output reg [`SBOL_FLASH_AW-1:0] flash_rd_addr,
  input wire flash_rd_valid,
  input wire [31:0] flash_rd_data,
  // ram write port
  output reg ram_wr_valid,
  output reg [`SBOL_RAM_AW-1:0] ram_wr_addr,
  output reg [31:0] ram_wr_data,
  input wire ram_wr_ready,
  // boot result
  output reg exec_start,
  output reg [`SBOL_RAM_AW-1:0] exec_addr,
  output reg boot_done,
  output reg boot_fail,
  output reg sec_loaded,
  output reg [31:0] tile_security_config,
  // security gating
  input wire jtag_req,
  output reg jtag_grant,
  input wire jtag_otp_req,
  output reg jtag_otp_grant,
  input wire link_ps_req,
  output reg link_ps_grant,
  output reg link_ps_refuse,
  input wire global_debug,
  output reg debug_req,
  output reg otp_redund_en,
  output reg [6:0] sec_gp_field,
  output reg [9:0] jtag_user_ext,
  // otp programming ports
  input wire port_we,
  input wire [23:0] port_res_id,
  input wire [31:0] port_wdata,
  output reg pgm_go,
  output reg pgm_sec_tgt,
  output reg [15:0] pgm_addr,
  output reg [31:0] pgm_data,
  output reg pgm_reject
);

  // one-hot states
  localparam [6:0] S_SEC = 7'h01;
  localparam [6:0] S_SIZE = 7'h02;
  localparam [6:0] S_PROG = 7'h04;
  localparam [6:0] S_CRC = 7'h08;
  localparam [6:0] S_DRAIN = 7'h10;
  localparam [6:0] S_RUN = 7'h20;
  localparam [6:0] S_FAIL = 7'h40;

  // reflected crc over one word, byte 0 bit 0 first
  function [31:0] crc_word;
    input [31:0] c;
    input [31:0] d;
    integer i;
    reg [31:0] r;
    begin
      r = c;
      for (i = 0; i < 32; i = i + 1) begin
        if (r[0] ^ d[i])
          r = (r >> 1) ^ `SBOL_CRC_POLY;
        else
          r = r >> 1;
      end
      crc_word = r;
    end
  endfunction

  reg [6:0] state;
  reg [6:0] next_state;
  reg from_otp;
  reg [31:0] size;
  reg [31:0] cnt;
  reg [31:0] crc;
  reg [15:0] pgm_ctrl;
  reg rd_busy;
  // second buffer entry; first entry is the ram port itself
  reg b1_v;
  reg [`SBOL_RAM_AW-1:0] b1_addr;
  reg [31:0] b1_data;

  wire src_valid;
  wire [31:0] src_data;
  wire word_in;
  wire buf_ready;
  wire push;
  wire pop;
  wire want_rd;
  wire crc_ok;
  wire [1:0] sect;
  wire sect_lock;

  ////////////////////////////////////////////////////////////////////////////
  // source mux
  // same image walk for flash
  assign src_valid = from_otp ? otp_rd_valid : flash_rd_valid;
  assign src_data = from_otp ? otp_rd_data : flash_rd_data;
  assign word_in = rd_busy & ((otp_rd_req & otp_rd_valid) | (flash_rd_req & flash_rd_valid));
  // buffer takes a word only while its spare slot is free
  assign buf_ready = ~b1_v;
  assign pop = ram_wr_valid & ram_wr_ready;
  assign push = word_in & state[2];
  // only fetch program words when they can be stored
  assign want_rd = ~rd_busy & (state[1] | state[3] | (state[2] & buf_ready));
  assign crc_ok = (src_data == `SBOL_CRC_SKIP) | (src_data == ~crc);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always @* begin
    next_state = state;
    case (state)
      S_SEC: begin
        if (word_in)
          next_state = S_SIZE;
      end
      S_SIZE: begin
        if (word_in)
          next_state = (src_data == 32'h00000000) ? S_CRC : S_PROG;
      end
      S_PROG: begin
        if (push && cnt == size - 32'h00000001)
          next_state = S_CRC;
      end
      S_CRC: begin
        if (word_in)
          next_state = crc_ok ? S_DRAIN : S_FAIL;
      end
      S_DRAIN: begin
        if (~ram_wr_valid && ~b1_v)
          next_state = S_RUN;
      end
      S_RUN: next_state = S_RUN;
      S_FAIL: next_state = S_FAIL;
      default: next_state = S_FAIL;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // boot sequencer and source reads
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= S_SEC;
      from_otp <= 1'b0;
      size <= 32'h00000000;
      cnt <= 32'h00000000;
      crc <= `SBOL_CRC_INIT;
      rd_busy <= 1'b0;
      otp_rd_req <= 1'b0;
      otp_rd_sec <= 1'b0;
      otp_rd_addr <= {`SBOL_OTP_AW{1'b0}};
      flash_rd_req <= 1'b0;
      flash_rd_addr <= {`SBOL_FLASH_AW{1'b0}};
      tile_security_config <= `SBOL_SEC_RESET;
      sec_loaded <= 1'b0;
      exec_start <= 1'b0;
      exec_addr <= `SBOL_RAM_BASE;
      boot_done <= 1'b0;
      boot_fail <= 1'b0;
    end else begin
      state <= next_state;
      exec_start <= 1'b0;
      if (state[0] && ~rd_busy) begin
        rd_busy <= 1'b1;
        otp_rd_req <= 1'b1;
        otp_rd_sec <= 1'b1;
      end else if (want_rd) begin
        rd_busy <= 1'b1;
        // otp boot from row 0 or flash
        if (from_otp) begin
          otp_rd_req <= 1'b1;
          otp_rd_sec <= 1'b0;
          // size at row 0, program from row 1, crc word right after the program
          otp_rd_addr <= cnt[`SBOL_OTP_AW-1:0] + {{(`SBOL_OTP_AW-1){1'b0}}, ~state[1]};
        end else begin
          flash_rd_req <= 1'b1;
          // same word offsets as the otp walk
          flash_rd_addr <= cnt[`SBOL_FLASH_AW-1:0]
            + {{(`SBOL_FLASH_AW-1){1'b0}}, ~state[1]};
        end
      end
      if (word_in) begin
        rd_busy <= 1'b0;
        otp_rd_req <= 1'b0;
        flash_rd_req <= 1'b0;
      end
      if (word_in && state[0]) begin
        tile_security_config <= otp_rd_data;
        sec_loaded <= 1'b1;
        from_otp <= otp_rd_data[`SBOL_SEC_OTP_BOOT];
      end
      if (word_in && state[1]) begin
        size <= src_data;
        crc <= crc_word(`SBOL_CRC_INIT, src_data);
      end
      if (push) begin
        cnt <= cnt + 32'h00000001;
        crc <= crc_word(crc, src_data);
      end
      if (state[4] && next_state[5]) begin
        exec_start <= 1'b1;
        exec_addr <= `SBOL_RAM_BASE;
        boot_done <= 1'b1;
      end
      if (state[3] && next_state[6])
        boot_fail <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-entry buffer toward ram
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ram_wr_valid <= 1'b0;
      ram_wr_addr <= `SBOL_RAM_BASE;
      ram_wr_data <= 32'h00000000;
      b1_v <= 1'b0;
      b1_addr <= `SBOL_RAM_BASE;
      b1_data <= 32'h00000000;
    end else begin
      if (pop) begin
        if (b1_v) begin
          ram_wr_addr <= b1_addr;
          ram_wr_data <= b1_data;
          b1_v <= push;
          b1_addr <= `SBOL_RAM_BASE + cnt[`SBOL_RAM_AW-1:0];
          b1_data <= src_data;
        end else begin
          ram_wr_valid <= push;
          ram_wr_addr <= `SBOL_RAM_BASE + cnt[`SBOL_RAM_AW-1:0];
          ram_wr_data <= src_data;
        end
      end else if (~ram_wr_valid) begin
        ram_wr_valid <= push;
        ram_wr_addr <= `SBOL_RAM_BASE + cnt[`SBOL_RAM_AW-1:0];
        ram_wr_data <= src_data;
      end else if (push) begin
        b1_v <= 1'b1;
        b1_addr <= `SBOL_RAM_BASE + cnt[`SBOL_RAM_AW-1:0];
        b1_data <= src_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // security gating, closed until security word is loaded
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      jtag_grant <= 1'b0;
      jtag_otp_grant <= 1'b0;
      link_ps_grant <= 1'b0;
      link_ps_refuse <= 1'b0;
      debug_req <= 1'b0;
      otp_redund_en <= 1'b0;
      sec_gp_field <= 7'h00;
      jtag_user_ext <= 10'h000;
    end else begin
      jtag_grant <= jtag_req & sec_loaded & ~tile_security_config[`SBOL_SEC_JTAG_OFF];
      jtag_otp_grant <= jtag_otp_req & sec_loaded
        & ~tile_security_config[`SBOL_SEC_JTAG_OTP_OFF]
        & ~tile_security_config[`SBOL_SEC_JTAG_OFF];
      link_ps_grant <= link_ps_req & sec_loaded & ~tile_security_config[`SBOL_SEC_LINK_OFF];
      link_ps_refuse <= link_ps_req & (~sec_loaded | tile_security_config[`SBOL_SEC_LINK_OFF]);
      debug_req <= global_debug & sec_loaded & ~tile_security_config[`SBOL_SEC_DBG_OFF];
      otp_redund_en <= sec_loaded & tile_security_config[`SBOL_SEC_REDUND];
      sec_gp_field <= tile_security_config[`SBOL_SEC_GP_HI:`SBOL_SEC_GP_LO];
      jtag_user_ext <= tile_security_config[`SBOL_SEC_UID_HI:`SBOL_SEC_UID_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // otp programming ports
  // sector from row address bits
  assign sect = pgm_addr[`SBOL_OTP_SECT_HI:`SBOL_OTP_SECT_LO];
  assign sect_lock = tile_security_config[`SBOL_SEC_LOCK_LO + sect];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pgm_addr <= 16'h0000;
      pgm_data <= 32'h00000000;
      pgm_ctrl <= 16'h0000;
      pgm_go <= 1'b0;
      pgm_sec_tgt <= 1'b0;
      pgm_reject <= 1'b0;
    end else begin
      pgm_go <= 1'b0;
      pgm_reject <= 1'b0;
      if (port_we && port_res_id == `SBOL_RES_PGM_ADDR)
        pgm_addr <= port_wdata[15:0];
      if (port_we && port_res_id == `SBOL_RES_PGM_DATA)
        pgm_data <= port_wdata;
      if (port_we && port_res_id == `SBOL_RES_PGM_CTRL) begin
        pgm_ctrl <= port_wdata[15:0];
        if (port_wdata[`SBOL_CTRL_GO]) begin
          pgm_sec_tgt <= port_wdata[`SBOL_CTRL_SEC_TGT];
          if (~sec_loaded || tile_security_config[`SBOL_SEC_MASTER_LOCK]
              || (~port_wdata[`SBOL_CTRL_SEC_TGT] && sect_lock))
            pgm_reject <= 1'b1;
          else
            pgm_go <= 1'b1;
        end
      end
    end
  end

endmodule // sbol_loader

//--- design/sbol_consts.vh
`ifndef SBOL_CONSTS_VH
`define SBOL_CONSTS_VH
// security register fields
`define SBOL_SEC_JTAG_OFF 0
`define SBOL_SEC_LINK_OFF 1
`define SBOL_SEC_OTP_BOOT 5
`define SBOL_SEC_REDUND 7
`define SBOL_SEC_LOCK_LO 8
`define SBOL_SEC_MASTER_LOCK 12
`define SBOL_SEC_JTAG_OTP_OFF 13
`define SBOL_SEC_DBG_OFF 14
`define SBOL_SEC_GP_HI 21
`define SBOL_SEC_GP_LO 15
`define SBOL_SEC_UID_HI 31
`define SBOL_SEC_UID_LO 22
`define SBOL_SEC_RESET 32'h00000000
// image layout and checksum
`define SBOL_CRC_POLY 32'hedb88320
`define SBOL_CRC_INIT 32'hffffffff
`define SBOL_CRC_SKIP 32'h0d15ab1e
`define SBOL_RAM_BASE 15'h0000
// otp geometry: 4 sectors of 512 rows
`define SBOL_OTP_AW 11
`define SBOL_OTP_SECT_HI 10
`define SBOL_OTP_SECT_LO 9
`define SBOL_FLASH_AW 19
`define SBOL_RAM_AW 15
// otp programming port resource ids
`define SBOL_RES_PGM_ADDR 24'h100200
`define SBOL_RES_PGM_DATA 24'h200100
`define SBOL_RES_PGM_CTRL 24'h100300
`define SBOL_CTRL_GO 0
`define SBOL_CTRL_SEC_TGT 1
`endif

//--- verif/sbol_chk_asserts.sv
module sbol_chk (
  // clock and reset
  input wire clk,
  input wire rst,
  // boot outcome
  input wire flash_rd_req,
  input wire exec_start,
  input wire [14:0] exec_addr,
  input wire boot_fail,
  input wire sec_loaded,
  input wire [31:0] tile_security_config,
  // access gates
  input wire jtag_req,
  input wire jtag_grant,
  input wire jtag_otp_grant,
  input wire link_ps_req,
  input wire link_ps_grant,
  input wire global_debug,
  input wire debug_req,
  input wire otp_redund_en,
  input wire [6:0] sec_gp_field,
  input wire [9:0] jtag_user_ext,
  // programming ports
  input wire port_we,
  input wire [23:0] port_res_id,
  input wire [31:0] port_wdata,
  input wire pgm_go,
  input wire pgm_sec_tgt,
  input wire [15:0] pgm_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  // short alias of the security word
  wire [31:0] sc = tile_security_config;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // boot source and program start
  property p_src; flash_rd_req |-> sec_loaded && !sc[5]; endproperty
  a_src: assert property (p_src) else $error("flash read against boot choice");
  property p_run; exec_start |-> exec_addr == 15'h0000 && !boot_fail; endproperty
  a_run: assert property (p_run) else $error("bad program start");
  // gates follow their security bits one cycle later
  property p_jtag; $past(sec_loaded) |-> jtag_grant == ($past(jtag_req) && !$past(sc[0])); endproperty
  a_jtag: assert property (p_jtag) else $error("test port gate wrong");
  property p_jotp; jtag_otp_grant |-> !sc[13] && !sc[0]; endproperty
  a_jotp: assert property (p_jotp) else $error("test port otp gate wrong");
  property p_link; $past(sec_loaded) |-> link_ps_grant == ($past(link_ps_req) && !$past(sc[1]));
  endproperty
  a_link: assert property (p_link) else $error("switch gate wrong");
  property p_dbg; $past(sec_loaded) |-> debug_req == ($past(global_debug) && !$past(sc[14]));
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug gate wrong");
  property p_fld; $past(sec_loaded, 2) |-> otp_redund_en == sc[7] && sec_gp_field == sc[21:15]
    && jtag_user_ext == sc[31:22]; endproperty
  a_fld: assert property (p_fld) else $error("security fields wrong");
  property p_go; pgm_go |-> $past(port_we) && $past(port_res_id) == 24'h100300
    && $past(port_wdata[0]) && !sc[12] && (pgm_sec_tgt || !sc[8 + pgm_addr[10:9]]); endproperty
  a_go: assert property (p_go) else $error("programming not allowed");
  // main scenarios
  c_start: cover property (exec_start);
  c_fail: cover property ($rose(boot_fail));
  c_go: cover property (pgm_go);
endmodule // sbol_chk

bind sbol_loader sbol_chk i_chk (.*);

//--- verif/sbol_mem_model.sv
module sbol_mem_model (
  // clock and answer delay
  input wire clk,
  input wire [3:0] lat,
  // otp read port
  input wire otp_rd_req,
  input wire otp_rd_sec,
  input wire [10:0] otp_rd_addr,
  output logic otp_rd_valid,
  output logic [31:0] otp_rd_data,
  // flash read port
  input wire flash_rd_req,
  input wire [18:0] flash_rd_addr,
  output logic flash_rd_valid,
  output logic [31:0] flash_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] otp [0:63];
  logic [31:0] flash [0:63];
  logic [31:0] sec_word;
  logic [3:0] oc = 4'h0;
  logic [3:0] fc = 4'h0;
  initial {otp_rd_valid, flash_rd_valid, otp_rd_data, flash_rd_data} = '0;
  // security row apart, word after lat cycles, data churns otherwise
  always @(posedge clk) begin
    if (otp_rd_req && !otp_rd_valid && oc >= lat) begin
      otp_rd_valid <= 1'b1;
      otp_rd_data <= otp_rd_sec ? sec_word : otp[otp_rd_addr[5:0]];
      oc <= 4'h0;
    end else begin
      otp_rd_valid <= 1'b0;
      otp_rd_data <= ~otp_rd_data;
      oc <= otp_rd_req ? oc + 4'h1 : 4'h0;
    end
  end
  always @(posedge clk) begin
    if (flash_rd_req && !flash_rd_valid && fc >= lat) begin
      flash_rd_valid <= 1'b1;
      flash_rd_data <= flash[flash_rd_addr[5:0]];
      fc <= 4'h0;
    end else begin
      flash_rd_valid <= 1'b0;
      flash_rd_data <= ~flash_rd_data;
      fc <= flash_rd_req ? fc + 4'h1 : 4'h0;
    end
  end
endmodule // sbol_mem_model

//--- verif/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, ram_wr_ready = 1, port_we = 0, stall = 0, fl = 0;
  logic jtag_req = 0, jtag_otp_req = 0, link_ps_req = 0, global_debug = 0;
  logic otp_rd_req, otp_rd_sec, otp_rd_valid, flash_rd_req, flash_rd_valid, ram_wr_valid;
  logic exec_start, boot_done, boot_fail, sec_loaded, jtag_grant, jtag_otp_grant, pgm_go;
  logic link_ps_grant, link_ps_refuse, debug_req, otp_redund_en, pgm_sec_tgt, pgm_reject;
  logic [10:0] otp_rd_addr;
  logic [18:0] flash_rd_addr;
  logic [14:0] ram_wr_addr, exec_addr;
  logic [31:0] otp_rd_data, flash_rd_data, ram_wr_data, tile_security_config, pgm_data;
  logic [31:0] port_wdata = 0;
  logic [31:0] img [0:63];
  logic [23:0] port_res_id = 0;
  logic [15:0] pgm_addr;
  logic [9:0] jtag_user_ext;
  logic [6:0] sec_gp_field;
  logic [3:0] lat = 0;
  int num_errors = 0, n_compared = 0, nw = 0, nst = 0, cyc = 0;

  sbol_loader i_dut (.*);
  sbol_mem_model i_mem (.*);

  initial forever #2.5 clk = ~clk;
  //////////////////////////////////////////////////////////////////////
  // receiver stalls six cycles of seven when asked
  always @(negedge clk) begin
    cyc <= cyc + 1;
    ram_wr_ready <= !stall || cyc % 7 == 0;
  end
  // watch ram writes, starts and flash use
  always @(posedge clk) begin
    if (ram_wr_valid && ram_wr_ready) begin
      check(ram_wr_addr, nw);
      check(ram_wr_data, img[nw]);
      nw++;
    end
    if (exec_start) nst++;
    if (flash_rd_req) fl = 1;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // reflected crc, one word lsb first
  function automatic logic [31:0] crc(input logic [31:0] c, input logic [31:0] w);
    for (int i = 0; i < 32; i++) c = (c >> 1) ^ ((c[0] ^ w[i]) ? 32'hedb88320 : 32'h0);
    return c;
  endfunction
  // load an image, reset, run the boot and judge it
  task automatic boot(input logic [31:0] sec, input int n, input int mode);
    logic [31:0] c, w;
    c = crc(32'hffffffff, n);
    i_mem.sec_word = sec;
    for (int i = 1; i <= n; i++) begin
      img[i - 1] = {i[7:0], 8'h5a, ~i[7:0], 8'hc3};
      c = crc(c, img[i - 1]);
    end
    for (int i = 0; i <= n + 1; i++) begin
      w = i == 0 ? n : i <= n ? img[i - 1] : mode == 1 ? 32'h0d15ab1e : mode == 2 ? c : ~c;
      i_mem.otp[i] = w;
      i_mem.flash[i] = w;
    end
    nw = 0;
    nst = 0;
    fl = 0;
    rst = 1;
    repeat (10) @(negedge clk);
    rst = 0;
    for (int k = 0; k < 4000 && !boot_done && !boot_fail; k++) @(negedge clk);
    repeat (16) @(negedge clk);
    check(fl, !sec[5]);
    check(tile_security_config, sec);
    check(nw, n);
    check(nst, mode != 2);
    check(boot_done, mode != 2);
    check(boot_fail, mode == 2);
  endtask
  task automatic pgm(input logic [15:0] a, input logic [1:0] ctl, input logic [1:0] exp);
    port_we = 1;
    port_res_id = 24'h100200;
    port_wdata = a;
    @(negedge clk);
    port_res_id = 24'h200100;
    port_wdata = 32'hc0de0000 | a;
    @(negedge clk);
    port_res_id = 24'h100300;
    port_wdata = ctl;
    @(negedge clk);
    port_we = 0;
    check({pgm_go, pgm_reject}, exp);
    check(pgm_addr, a);
    check(pgm_data, 32'hc0de0000 | a);
    @(negedge clk);
  endtask
  task automatic gate(input logic [31:0] sec, input logic [4:0] exp);
    boot(sec, 1, 1);
    {jtag_req, jtag_otp_req, link_ps_req, global_debug} = 4'hf;
    repeat (2) @(negedge clk);
    check({jtag_grant, jtag_otp_grant, link_ps_grant, link_ps_refuse, debug_req}, exp);
    check({jtag_user_ext, sec_gp_field, otp_redund_en}, {sec[31:15], sec[7]});
    {jtag_req, jtag_otp_req, link_ps_req, global_debug} = 4'h0;
  endtask
  //////////////////////////////////////////////////////////////////////
  task t_otp_boot;
    lat = 4'h3;
    stall = 1;
    boot(32'h00000020, 12, 0);
    $display("otp boot with stalls done");
  endtask
  task t_flash_skip;
    lat = 4'h0;
    stall = 0;
    boot(32'h00000000, 5, 1);
    boot(32'h00000000, 0, 0);
    $display("flash boot and empty image done");
  endtask
  task t_bad_crc;
    lat = 4'h1;
    stall = 1;
    boot(32'h00000020, 4, 2);
    $display("bad checksum done");
  endtask
  task t_locks_a;
    stall = 0;
    gate(32'ha96ac281, 5'b00100);
    pgm(16'h0010, 2'b01, 2'b10);
    pgm(16'h0210, 2'b01, 2'b01);
    pgm(16'h0210, 2'b11, 2'b10);
    pgm(16'h0610, 2'b01, 2'b10);
    $display("sector locks done");
  endtask
  task t_locks_b;
    gate(32'h00003002, 5'b10011);
    pgm(16'h0010, 2'b01, 2'b01);
    pgm(16'h0010, 2'b11, 2'b01);
    gate(32'h00000000, 5'b11101);
    $display("master lock done");
  endtask
  task results;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // main sequence
  initial begin
    t_otp_boot;
    t_flash_skip;
    t_bad_crc;
    t_locks_a;
    t_locks_b;
    results;
  end
  // watchdog
  initial begin
    #400us;
    num_errors++;
    results;
  end
endmodule // testbench
